// [ebarb_pkg.sv]
// Shared constants for the external bus arbiter: states, timing figures.
// Assumes one 200 MHz reference clock; bus clock edges arrive as enables.
package ebarb_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Clock and half-cycle timing
  localparam int unsigned REF_CLK_MHZ       = 200;
  localparam int unsigned REF_PER_HALF_BUS  = 1;   // Reference cycles per bus half-cycle
  // Least strobe-negated time before high impedance, in tenths of a bus cycle
  localparam int unsigned STROBE_NEG_TENTHS = 15;
  // Same figure in bus half-cycles, rounded up
  localparam int unsigned STROBE_NEG_HALF   = (STROBE_NEG_TENTHS * 2 + 9) / 10;
  // Half-cycles from grant assertion to strobes going high impedance
  localparam int unsigned GRANT_TO_HIZ_HALF = 2;
  // Idle half-cycles needed before the grant edge
  localparam logic [1:0]  NEG_BEFORE_GRANT  = 2'(STROBE_NEG_HALF - GRANT_TO_HIZ_HALF);
  localparam logic [1:0]  NEG_CNT_MAX       = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values of pin-level outputs (active-low pins idle high)
  localparam logic PIN_NEGATED = 1'b1;
  localparam logic PIN_ASSERTED = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // Arbiter states, one-hot
  typedef enum logic [12:0] {
    ST_BOOT     = 13'h0001,
    ST_M_OWN    = 13'h0002,
    ST_M_PRECHG = 13'h0004,
    ST_M_GRANT  = 13'h0008,
    ST_M_AD_OFF = 13'h0010,
    ST_M_REL    = 13'h0020,
    ST_M_RETAKE = 13'h0040,
    ST_S_IDLE   = 13'h0080,
    ST_S_REQ    = 13'h0100,
    ST_S_NEG    = 13'h0200,
    ST_S_OWN    = 13'h0400,
    ST_S_DROP   = 13'h0800,
    ST_S_AD_OFF = 13'h1000
  } ebarb_state_t;

endpackage

// [ebarb_phase.sv]
// Bus clock phase generator: one-cycle rise and fall enables.
// Assumes the bus clock is derived from ref_clk and both edges are used.
`timescale 1ns/1ps

module ebarb_phase
  import ebarb_pkg::*;
#(
  parameter int unsigned DIV = REF_PER_HALF_BUS
) (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic sys_rst,
  // Edge enables
  output logic      rise_en,
  output logic      fall_en
);

  // Divider must fit the 8-bit counter; refused at elaboration
  if (DIV < 1 || DIV > 255) begin : g_div_check
    $error("ebarb_phase: DIV out of range");
  end

  logic [7:0] cnt_reg;
  logic [7:0] cnt_next;
  logic       half_reg;
  logic       half_next;
  logic       rise_next;
  logic       fall_next;

  ////////////////////////////////////////////////////////////////////////////
  // Count reference cycles, flip bus phase at each half period
  always_comb begin
    cnt_next  = cnt_reg + 8'h01;
    half_next = half_reg;
    rise_next = 1'b0;
    fall_next = 1'b0;
    if (cnt_reg == 8'(DIV - 1)) begin
      cnt_next  = 8'h00;
      half_next = ~half_reg;
      rise_next = ~half_reg;  // Low half ends: rising edge
      fall_next = half_reg;
    end
  end

  // Registers only
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      cnt_reg  <= 8'h00;
      half_reg <= 1'b0;
      rise_en  <= 1'b0;
      fall_en  <= 1'b0;
    end else begin
      cnt_reg  <= cnt_next;
      half_reg <= half_next;
      rise_en  <= rise_next;
      fall_en  <= fall_next;
    end
  end

endmodule

// [ebarb_top.sv]
// External bus arbiter: master, slave and partial-share master modes.
// Assumes the bus controller reports cycle/precharge state synchronously.
`timescale 1ns/1ps

// Behaviour
// - Master keeps the bus unless a release request is presented.
// - On release request, finish current cycle, release, assert grant low.
// - Release request going high returns bus; grant negated, bus reused.
// - Released bus: all bus pins high-Z except clock enable, grant, DMA acks.
// - Wait for precharge, and precharge open SDRAM banks, before releasing.
// - Grant at fall, address/data off at rise, strobes off at next fall.
// - Strobes stay negated at least 1.5 cycles before going high-Z.
// - Bus request inputs are sampled at falling edges.
// - Request negation seen at fall: drop grant, drive negated strobes now.
// - Bus cycle may start no earlier than the rise driving address/data.
// - Refresh while released, nothing waiting: negate grant, refresh on return.
// - Access already waiting at refresh: keep grant, do access then refresh.
// - Slave mode leaves the bus released and arbitrates before any access.
// - Slave releases bus in reset; first arbitration is the vector fetch.
// - Slave asserts its bus request at a falling edge.
// - Acknowledge low at fall: drive negated strobes, start cycle at rise.
// - Slave drops request, then address/data off, then strobes off.
// - Slave holds the bus until memory precharge finishes.
// - Slave mode ignores refresh requests.
// - Partial-share master arbitrates only chip-select space 2.
// - Priority: refresh, external requests, DMA, CPU.
// - No release inside a cache-fill burst or 16-byte DMA block.
module ebarb_top
  import ebarb_pkg::*;
(
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic sys_rst,
  // Mode selection
  input  wire logic mode_master_pin,
  input  wire logic partial_share_enable,
  // Arbitration link
  input  wire logic bus_release_request_n,
  input  wire logic bus_acknowledge_in_n,
  output logic      bus_grant_out_n,
  output logic      bus_request_out_n,
  // Internal requesters
  input  wire logic refresh_req,
  input  wire logic dma_req,
  input  wire logic cpu_req,
  input  wire logic req_cs2,
  output logic      grant_refresh,
  output logic      grant_dma,
  output logic      grant_cpu,
  output logic      vector_fetch_cycle,
  // Bus controller status
  input  wire logic cycle_busy,
  input  wire logic burst_lock,
  input  wire logic precharge_busy,
  input  wire logic sdram_banks_active,
  output logic      precharge_all_cmd,
  // Pin drive control
  output logic      addr_data_oe,
  output logic      ctrl_oe,
  output logic      ctrl_force_negate,
  // Always-driven pins
  input  wire logic sdram_cke_in,
  input  wire logic dma_ack_zero_in,
  input  wire logic dma_ack_one_in,
  output logic      sdram_clock_enable,
  output logic      dma_transfer_ack_zero,
  output logic      dma_transfer_ack_one
);

  logic rise_en;
  logic fall_en;

  ebarb_phase #(.DIV(REF_PER_HALF_BUS)) i_ebarb_phase (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .rise_en (rise_en),
    .fall_en (fall_en)
  );

  ////////////////////////////////////////////////////////////////////////////
  // State
  ebarb_state_t state_reg,  state_next;
  logic         master_reg, master_next;
  logic         pshare_reg, pshare_next;
  logic         rel_seen_reg, rel_seen_next;
  logic         refr_seen_reg, refr_seen_next;
  logic         defer_reg,  defer_next;
  logic         vec_reg,    vec_next;
  logic [1:0]   neg_cnt_reg, neg_cnt_next;
  logic         grant_n_next, req_n_next;
  logic         g_ref_next, g_dma_next, g_cpu_next, pre_next;
  logic         ad_raw_next, ctrl_raw_next, neg_next;
  logic         ad_raw_reg, ctrl_raw_reg;

  // Refresh exists only for a master, never in slave mode
  logic refresh_eff;
  logic access_pend;
  logic idle_now;
  logic can_start;
  logic shared_path;

  assign refresh_eff = refresh_req & master_reg;
  assign access_pend = dma_req | cpu_req;
  // Not mid-cycle, not in a locked burst, no grant just issued
  assign idle_now    = ~cycle_busy & ~burst_lock & ~grant_refresh
                       & ~grant_dma & ~grant_cpu;
  assign can_start   = rise_en & idle_now;
  assign shared_path = pshare_reg & req_cs2;

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic for arbitration and pin drive
  always_comb begin
    state_next     = state_reg;
    master_next    = sys_rst ? mode_master_pin : master_reg;
    pshare_next    = pshare_reg | (partial_share_enable & master_reg);
    rel_seen_next  = rel_seen_reg;
    refr_seen_next = refr_seen_reg;
    defer_next     = defer_reg;
    vec_next       = vec_reg;
    grant_n_next   = bus_grant_out_n;
    req_n_next     = bus_request_out_n;
    g_ref_next     = 1'b0;
    g_dma_next     = 1'b0;
    g_cpu_next     = 1'b0;
    pre_next       = 1'b0;
    ad_raw_next    = ad_raw_reg;
    ctrl_raw_next  = ctrl_raw_reg;
    neg_next       = ctrl_force_negate;
    // Count half-cycles with strobes negated, saturating
    neg_cnt_next   = neg_cnt_reg;
    if (cycle_busy) begin
      neg_cnt_next = 2'h0;
    end else if ((rise_en | fall_en) && neg_cnt_reg != NEG_CNT_MAX) begin
      neg_cnt_next = neg_cnt_reg + 2'h1;
    end
    // Release request is only looked at on falling edges
    if (fall_en) begin
      rel_seen_next = ~bus_release_request_n & master_reg & ~pshare_reg;
    end

    case (state_reg)
      ST_BOOT: begin
        state_next = master_reg ? ST_M_OWN : ST_S_IDLE;
        ad_raw_next   = master_reg;
        ctrl_raw_next = master_reg;
      end
      ST_M_OWN, ST_M_RETAKE: begin
        if (state_reg == ST_M_RETAKE && rise_en) begin
          state_next  = ST_M_OWN;
          ad_raw_next = 1'b1;
          neg_next    = 1'b0;
        end
        // Cycle start never precedes address/data drive
        if (can_start) begin
          if (refresh_eff && !(defer_reg && access_pend)) begin
            g_ref_next     = 1'b1;
            refr_seen_next = 1'b0;
            defer_next     = 1'b0;
          end else if (rel_seen_reg) begin
            // External request outranks DMA and CPU
          end else if (access_pend && shared_path) begin
            // Space 2 in partial share goes through the slave handshake
            if (state_reg == ST_M_OWN) begin
              state_next = ST_S_IDLE;
            end
          end else if (dma_req) begin
            g_dma_next = 1'b1;
          end else if (cpu_req) begin
            g_cpu_next = 1'b1;
          end
        end
        // Release only at a fall, between cycles, after precharge
        if (state_reg == ST_M_OWN && fall_en && !bus_release_request_n && master_reg
            && !pshare_reg && !refresh_eff && idle_now) begin
          state_next = ST_M_PRECHG;
          pre_next   = sdram_banks_active;
        end
      end
      ST_M_PRECHG: begin
        if (fall_en && bus_release_request_n) begin
          state_next = ST_M_OWN;
        end else if (fall_en && !precharge_busy && !sdram_banks_active && idle_now
                     && neg_cnt_reg >= NEG_BEFORE_GRANT) begin
          state_next   = ST_M_GRANT;
          grant_n_next = PIN_ASSERTED;
          neg_next     = 1'b1;
        end
      end
      ST_M_GRANT: begin
        if (rise_en) begin
          state_next  = ST_M_AD_OFF;
          ad_raw_next = 1'b0;
        end
      end
      ST_M_AD_OFF: begin
        if (fall_en) begin
          state_next    = ST_M_REL;
          ctrl_raw_next = 1'b0;
        end
      end
      ST_M_REL: begin
        if (fall_en) begin
          if (bus_release_request_n) begin
            state_next     = ST_M_RETAKE;
            grant_n_next   = PIN_NEGATED;
            ctrl_raw_next  = 1'b1;
            neg_next       = 1'b1;
          end else if (refresh_eff && !refr_seen_reg) begin
            refr_seen_next = 1'b1;
            defer_next     = access_pend;
            if (!access_pend) begin
              grant_n_next = PIN_NEGATED;
            end
          end
        end
      end
      ST_S_IDLE: begin
        if (fall_en && (access_pend || vec_reg)) begin
          state_next = ST_S_REQ;
          req_n_next = PIN_ASSERTED;
        end
      end
      ST_S_REQ: begin
        if (fall_en && !bus_acknowledge_in_n) begin
          state_next    = ST_S_NEG;
          ctrl_raw_next = 1'b1;
          neg_next      = 1'b1;
        end
      end
      ST_S_NEG: begin
        if (rise_en) begin
          state_next  = ST_S_OWN;
          ad_raw_next = 1'b1;
          neg_next    = 1'b0;
          if (vec_reg && !master_reg) begin
            g_cpu_next = 1'b1;
            vec_next   = 1'b0;
          end else if (dma_req) begin
            g_dma_next = 1'b1;
          end else begin
            g_cpu_next = 1'b1;
          end
        end
      end
      ST_S_OWN: begin
        // Hold until the cycle ends and memory precharge is done
        if (fall_en && idle_now && !precharge_busy) begin
          state_next = ST_S_DROP;
          req_n_next = PIN_NEGATED;
          neg_next   = 1'b1;
        end
      end
      ST_S_DROP: begin
        if (fall_en) begin
          state_next  = ST_S_AD_OFF;
          ad_raw_next = 1'b0;
        end
      end
      ST_S_AD_OFF: begin
        if (fall_en) begin
          state_next    = pshare_reg ? ST_M_OWN : ST_S_IDLE;
          ctrl_raw_next = 1'b0;
          neg_next      = pshare_reg ? 1'b0 : 1'b1;
        end
      end
      default: begin
        state_next = ST_BOOT;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers; reset releases the bus and queues the vector fetch
  always_ff @(posedge ref_clk) begin
    master_reg <= master_next;
    if (sys_rst) begin
      state_reg             <= ST_BOOT;
      pshare_reg            <= 1'b0;
      rel_seen_reg          <= 1'b0;
      refr_seen_reg         <= 1'b0;
      defer_reg             <= 1'b0;
      vec_reg               <= 1'b1;
      neg_cnt_reg           <= 2'h0;
      bus_grant_out_n       <= PIN_NEGATED;
      bus_request_out_n     <= PIN_NEGATED;
      grant_refresh         <= 1'b0;
      grant_dma             <= 1'b0;
      grant_cpu             <= 1'b0;
      precharge_all_cmd     <= 1'b0;
      ad_raw_reg            <= 1'b0;
      ctrl_raw_reg          <= 1'b0;
      addr_data_oe          <= 1'b0;
      ctrl_oe               <= 1'b0;
      ctrl_force_negate     <= 1'b1;
      vector_fetch_cycle    <= 1'b0;
      sdram_clock_enable    <= 1'b0;
      dma_transfer_ack_zero <= 1'b0;
      dma_transfer_ack_one  <= 1'b0;
    end else begin
      state_reg             <= state_next;
      pshare_reg            <= pshare_next;
      rel_seen_reg          <= rel_seen_next;
      refr_seen_reg         <= refr_seen_next;
      defer_reg             <= defer_next;
      vec_reg               <= vec_next;
      neg_cnt_reg           <= neg_cnt_next;
      bus_grant_out_n       <= grant_n_next;
      bus_request_out_n     <= req_n_next;
      grant_refresh         <= g_ref_next;
      grant_dma             <= g_dma_next;
      grant_cpu             <= g_cpu_next;
      precharge_all_cmd     <= pre_next;
      ad_raw_reg            <= ad_raw_next;
      ctrl_raw_reg          <= ctrl_raw_next;
      // Partial share keeps the pins driven; an outside buffer isolates them
      addr_data_oe          <= ad_raw_next | pshare_next;
      ctrl_oe               <= ctrl_raw_next | pshare_next;
      ctrl_force_negate     <= neg_next;
      vector_fetch_cycle    <= vec_reg & ~master_reg;
      // These stay driven even with the bus released
      sdram_clock_enable    <= sdram_cke_in;
      dma_transfer_ack_zero <= dma_ack_zero_in;
      dma_transfer_ack_one  <= dma_ack_one_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  sequence ad_off_s;
    !addr_data_oe && ctrl_oe;
  endsequence
  sequence ctrl_off_s;
    !addr_data_oe && !ctrl_oe;
  endsequence

  own_hold_a: assert property (
    (state_reg == ST_M_OWN && bus_release_request_n) |=> bus_grant_out_n)
    else $error("grant asserted without release request");
  grant_idle_a: assert property (
    $fell(bus_grant_out_n) |-> $past(!cycle_busy && !burst_lock && !precharge_busy))
    else $error("bus released during cycle or precharge");
  release_seq_a: assert property (
    ($fell(bus_grant_out_n) && !pshare_reg) |-> addr_data_oe ##1 ad_off_s ##1 ctrl_off_s)
    else $error("release sequence out of order");
  released_hiz_a: assert property (
    (state_reg == ST_M_REL) |-> (!addr_data_oe && !ctrl_oe && !bus_grant_out_n)
                                || bus_grant_out_n)
    else $error("pins driven while bus released");
  strobe_neg_a: assert property (
    $fell(bus_grant_out_n) |-> $past(neg_cnt_reg) >= NEG_BEFORE_GRANT)
    else $error("strobes negated too briefly");
  fall_sample_a: assert property (
    ($fell(bus_grant_out_n) || $rose(bus_grant_out_n)) |-> $past(fall_en))
    else $error("grant moved off a falling edge");
  retake_a: assert property (
    (state_reg == ST_M_REL && fall_en && bus_release_request_n)
      |=> bus_grant_out_n && ctrl_oe && ctrl_force_negate && !addr_data_oe)
    else $error("bus retake sequence wrong");
  refresh_neg_a: assert property (
    (state_reg == ST_M_REL && fall_en && !bus_release_request_n && refresh_eff
     && !refr_seen_reg && !access_pend) |=> bus_grant_out_n)
    else $error("grant not dropped for refresh");
  slave_req_a: assert property (
    $fell(bus_request_out_n) |-> $past(fall_en) && !master_reg || pshare_reg)
    else $error("request asserted off a falling edge");
  slave_ack_a: assert property (
    (state_reg == ST_S_REQ && fall_en && !bus_acknowledge_in_n)
      |=> ctrl_oe && ctrl_force_negate ##1 addr_data_oe && !ctrl_force_negate)
    else $error("slave bus take sequence wrong");
  no_refresh_a: assert property (
    !master_reg |-> !grant_refresh)
    else $error("refresh granted in slave mode");

endmodule

// [ebarb_partner.sv]
// Partner model: an external bus master on the arbitration link.
// Assumes the bench says when it wants the bus and how slowly to acknowledge.
`timescale 1ns/1ps

module ebarb_partner #(
  parameter int unsigned HOLD_MAX = 200
) (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       sys_rst,
  // Bench control
  input  wire logic       take_bus,
  input  wire logic [7:0] ack_delay,
  // Arbitration link
  input  wire logic       bus_grant_out_n,
  input  wire logic       bus_request_out_n,
  output logic            bus_release_request_n,
  output logic            bus_acknowledge_in_n
);
  int hold_cnt;
  int ack_cnt;

  // Non-blocking update at the rise; bench controls set at the fall are settled
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      bus_release_request_n <= 1'b1;
      bus_acknowledge_in_n  <= 1'b1;
      hold_cnt              <= 0;
      ack_cnt               <= 0;
    end else begin
      // Bounded hold so the owner's refresh is never starved
      hold_cnt              <= bus_grant_out_n ? 0 : hold_cnt + 1;
      bus_release_request_n <= !(take_bus && hold_cnt < HOLD_MAX);
      // Slow acknowledge: a prompt answer would hide ordering faults
      ack_cnt               <= bus_request_out_n ? 0 : ack_cnt + 1;
      bus_acknowledge_in_n  <= bus_request_out_n || ack_cnt < int'(ack_delay);
    end
  end
endmodule

// [external_bus_master_slave_arbiter_bench.sv]
// Bench for the external bus arbiter in master, partial-share and slave modes.
// Assumes the partner model on the arbitration link; inputs move at negedge.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin num_errors++; \
  $display("MISMATCH %s expected %0h seen %0h", nm, e, g); end end
`define WAIT_FOR(c) begin for (w = 0; w < 300 && (c) !== 1'b1; w++) @(negedge ref_clk); \
  if ((c) !== 1'b1) begin num_errors++; $display("MISMATCH wait expected 1 seen 0"); \
  give_verdict(); end end

module external_bus_master_slave_arbiter_bench;
  // Stimulus
  logic ref_clk = 1'b0, sys_rst = 1'b1, mode_master_pin = 1'b1, partial_share_enable = 1'b0;
  logic refresh_req = 1'b0, dma_req = 1'b0, cpu_req = 1'b0, req_cs2 = 1'b0;
  logic cycle_busy = 1'b0, burst_lock = 1'b0, precharge_busy = 1'b0, sdram_banks_active = 1'b0;
  logic sdram_cke_in = 1'b0, dma_ack_zero_in = 1'b0, dma_ack_one_in = 1'b0, take_bus = 1'b0;
  logic [7:0] ack_delay = 8'h02;
  // Observed
  logic bus_release_request_n, bus_acknowledge_in_n, bus_grant_out_n, bus_request_out_n;
  logic grant_refresh, grant_dma, grant_cpu, vector_fetch_cycle, precharge_all_cmd;
  logic addr_data_oe, ctrl_oe, ctrl_force_negate;
  logic sdram_clock_enable, dma_transfer_ack_zero, dma_transfer_ack_one;
  int   num_errors = 0, compares = 0, w;

  // 200 MHz clock
  always #2.5 ref_clk = ~ref_clk;

  ebarb_top i_ebarb_top (
    .ref_clk, .sys_rst, .mode_master_pin, .partial_share_enable,
    .bus_release_request_n, .bus_acknowledge_in_n, .bus_grant_out_n, .bus_request_out_n,
    .refresh_req, .dma_req, .cpu_req, .req_cs2, .grant_refresh, .grant_dma, .grant_cpu,
    .vector_fetch_cycle, .cycle_busy, .burst_lock, .precharge_busy, .sdram_banks_active,
    .precharge_all_cmd, .addr_data_oe, .ctrl_oe, .ctrl_force_negate, .sdram_cke_in,
    .dma_ack_zero_in, .dma_ack_one_in, .sdram_clock_enable, .dma_transfer_ack_zero,
    .dma_transfer_ack_one
  );

  ebarb_partner i_ebarb_partner (
    .ref_clk, .sys_rst, .take_bus, .ack_delay, .bus_grant_out_n, .bus_request_out_n,
    .bus_release_request_n, .bus_acknowledge_in_n
  );

  ////////////////////////////////////////////////////////////////////////////
  // Closing report, reached from the end of the run or a spent wait
  task automatic give_verdict();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Two-cycle reset; strap and share level held while reset is high
  task automatic do_reset(input logic master, input logic pshare);
    sys_rst = 1'b1;
    mode_master_pin = master;
    partial_share_enable = pshare;
    repeat (2) @(negedge ref_clk);
    `CHK("grant_n in reset", 1'b1, bus_grant_out_n)
    `CHK("request_n in reset", 1'b1, bus_request_out_n)
    `CHK("ad_oe in reset", 1'b0, addr_data_oe)
    sys_rst = 1'b0;
    repeat (3) @(negedge ref_clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic master_hold();
    repeat (10) @(negedge ref_clk);
    `CHK("grant_n idle", 1'b1, bus_grant_out_n)
    `CHK("ad_oe idle", 1'b1, addr_data_oe)
    `CHK("ctrl_oe idle", 1'b1, ctrl_oe)
  endtask

  // Release held off by a busy cycle, a burst and open banks
  task automatic master_release();
    cycle_busy = 1'b1;
    burst_lock = 1'b1;
    sdram_banks_active = 1'b1;
    take_bus = 1'b1;
    repeat (12) @(negedge ref_clk);
    `CHK("grant_n cycle busy", 1'b1, bus_grant_out_n)
    cycle_busy = 1'b0;
    repeat (12) @(negedge ref_clk);
    `CHK("grant_n in burst", 1'b1, bus_grant_out_n)
    burst_lock = 1'b0;
    `WAIT_FOR(precharge_all_cmd)
    `CHK("grant_n banks open", 1'b1, bus_grant_out_n)
    sdram_banks_active = 1'b0;
    `WAIT_FOR(!bus_grant_out_n)
    `CHK("ad_oe at grant", 1'b1, addr_data_oe)
    `CHK("negate at grant", 1'b1, ctrl_force_negate)
    `WAIT_FOR(!addr_data_oe)
    `CHK("ctrl_oe after ad off", 1'b1, ctrl_oe)
    `WAIT_FOR(!ctrl_oe)
    sdram_cke_in = 1'b1;
    dma_ack_zero_in = 1'b1;
    dma_ack_one_in = 1'b1;
    repeat (2) @(negedge ref_clk);
    `CHK("cke released", 1'b1, sdram_clock_enable)
    `CHK("ack0 released", 1'b1, dma_transfer_ack_zero)
    `CHK("ack1 released", 1'b1, dma_transfer_ack_one)
    take_bus = 1'b0;
    `WAIT_FOR(bus_grant_out_n)
    `CHK("ctrl_oe on retake", 1'b1, ctrl_oe)
    `CHK("ad_oe before rise", 1'b0, addr_data_oe)
    cpu_req = 1'b1;
    `WAIT_FOR(grant_cpu)
    `CHK("ad_oe at cycle", 1'b1, addr_data_oe)
    `CHK("grant_n resumed", 1'b1, bus_grant_out_n)
    cpu_req = 1'b0;
  endtask

  task automatic refresh_cases();
    take_bus = 1'b1;
    `WAIT_FOR(!ctrl_oe)
    refresh_req = 1'b1;
    `WAIT_FOR(bus_grant_out_n)
    for (int i = 0; i < 6; i++) begin
      @(negedge ref_clk);
      `CHK("refresh before return", 1'b0, grant_refresh)
    end
    take_bus = 1'b0;
    `WAIT_FOR(grant_refresh)
    refresh_req = 1'b0;
    take_bus = 1'b1;
    `WAIT_FOR(!ctrl_oe)
    cpu_req = 1'b1;
    repeat (4) @(negedge ref_clk);
    refresh_req = 1'b1;
    for (int i = 0; i < 8; i++) begin
      @(negedge ref_clk);
      `CHK("grant_n kept", 1'b0, bus_grant_out_n)
    end
    take_bus = 1'b0;
    `WAIT_FOR(grant_cpu | grant_refresh)
    `CHK("waiting access first", 1'b1, grant_cpu)
    cpu_req = 1'b0;
    `WAIT_FOR(grant_refresh)
    refresh_req = 1'b0;
  endtask

  // Coinciding internal requests come out highest first
  task automatic priority_order();
    logic [1:0] seen[$];
    refresh_req = 1'b1;
    dma_req = 1'b1;
    cpu_req = 1'b1;
    for (int i = 0; i < 60 && seen.size() < 3; i++) begin
      @(negedge ref_clk);
      if (grant_refresh === 1'b1) begin seen.push_back(2'h1); refresh_req = 1'b0; end
      if (grant_dma === 1'b1) begin seen.push_back(2'h2); dma_req = 1'b0; end
      if (grant_cpu === 1'b1) begin seen.push_back(2'h3); cpu_req = 1'b0; end
    end
    `CHK("first grant", 2'h1, seen[0])
    `CHK("second grant", 2'h2, seen[1])
    `CHK("third grant", 2'h3, seen[2])
  endtask

  task automatic partial_share();
    take_bus = 1'b1;
    repeat (12) @(negedge ref_clk);
    `CHK("grant_n shared", 1'b1, bus_grant_out_n)
    take_bus = 1'b0;
    cpu_req = 1'b1;
    `WAIT_FOR(grant_cpu)
    `CHK("no request off cs2", 1'b1, bus_request_out_n)
    req_cs2 = 1'b1;
    `WAIT_FOR(!bus_request_out_n)
    `CHK("pins kept driven", 1'b1, addr_data_oe)
    `WAIT_FOR(grant_cpu)
    cpu_req = 1'b0;
    req_cs2 = 1'b0;
    `WAIT_FOR(bus_request_out_n)
  endtask

  task automatic slave_mode();
    ack_delay = 8'h06;
    do_reset(1'b0, 1'b0);
    `WAIT_FOR(!bus_request_out_n)
    `CHK("vector pending", 1'b1, vector_fetch_cycle)
    `CHK("ad_oe before ack", 1'b0, addr_data_oe)
    `WAIT_FOR(ctrl_oe)
    `CHK("negate on ack", 1'b1, ctrl_force_negate)
    `CHK("ad_oe until rise", 1'b0, addr_data_oe)
    `WAIT_FOR(grant_cpu)
    `CHK("vector grant", 1'b1, vector_fetch_cycle)
    `CHK("ad_oe at cycle", 1'b1, addr_data_oe)
    cycle_busy = 1'b1;
    precharge_busy = 1'b1;
    repeat (6) @(negedge ref_clk);
    cycle_busy = 1'b0;
    repeat (6) @(negedge ref_clk);
    `CHK("held in precharge", 1'b0, bus_request_out_n)
    precharge_busy = 1'b0;
    `WAIT_FOR(bus_request_out_n)
    `CHK("ad_oe after drop", 1'b1, addr_data_oe)
    `WAIT_FOR(!addr_data_oe)
    `CHK("ctrl_oe after ad off", 1'b1, ctrl_oe)
    `WAIT_FOR(!ctrl_oe)
    refresh_req = 1'b1;
    for (int i = 0; i < 12; i++) begin
      @(negedge ref_clk);
      `CHK("refresh ignored", 1'b1, bus_request_out_n)
      `CHK("no refresh grant", 1'b0, grant_refresh)
    end
    refresh_req = 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    do_reset(1'b1, 1'b0);
    master_hold();
    master_release();
    refresh_cases();
    priority_order();
    do_reset(1'b1, 1'b1);
    partial_share();
    slave_mode();
    give_verdict();
  end
endmodule
